// >>> bench/ppgen_rx_model.sv
// receiver model for the pattern stream: accepts bits with random stalls
// assumes the generator offers one bit per cycle under valid and ready
`timescale 1ns/1ps

module ppgen_rx_model
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control from the bench
    input wire logic stall_en,
    // stream handshake
    output logic out_ready
);
    int seed = 7;

    // ------------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------------
    // random stalls let the two-entry buffer fill and refuse
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            out_ready <= 1'b0;
        else
            out_ready <= stall_en ? (($random(seed) & 1) != 0) : 1'b1;
    end
endmodule : ppgen_rx_model

// >>> bench/testbench.sv
// self-checking bench for the bit-pattern generator
// assumes the generator core and the receiver model are compiled before it
`timescale 1ns/1ps
`include "ppgen_consts.svh"

module testbench
    import ppgen_pkg::*;
;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, ab_select, rx_stall;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, r2;
    logic [3:0] pstrb;
    logic out_ready, out_valid, out_data, out_sync, out_ab;
    logic [33:0] apb_q[$];
    logic [2:0] exp_q[$];
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 7;
    int n_tab[7] = '{7, 9, 11, 15, 20, 23, 31};
    int t_tab[7] = '{6, 5, 9, 14, 3, 18, 28};

    ppgen_top dut_u (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .AB_SELECT(ab_select), .OUT_READY(out_ready),
        .OUT_VALID(out_valid), .OUT_DATA(out_data), .OUT_SYNC(out_sync), .OUT_AB(out_ab));
    ppgen_rx_model rx_u (.clk(clk), .reset_n(reset_n), .stall_en(rx_stall),
        .out_ready(out_ready));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task conclude;
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // the whole run needs about 12.5k cycles even with heavy stalling
    always @(posedge clk)
    begin
        cycles++;
        ab_select <= 1'($random(seed));
        if (cycles == 40000)
        begin
            failures++;
            conclude();
        end
    end

    // oldest note is compared against each completed transfer
    always @(posedge clk)
    begin
        if (reset_n && psel && penable && pready === 1'b1 && apb_q.size() > 0)
        begin
            check("pslverr", {31'h0, pslverr}, {31'h0, apb_q[0][32]});
            if (apb_q[0][33])
                check("prdata", prdata, apb_q[0][31:0]);
            void'(apb_q.pop_front());
        end
        if (reset_n && out_valid === 1'b1 && out_ready === 1'b1 && exp_q.size() > 0)
            check("stream", {29'h0, out_data, out_sync, out_ab}, {29'h0, exp_q.pop_front()});
    end

    // ------------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] exp_d, input logic exp_err);
        apb_q.push_back({~wr, exp_err, exp_d});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // expected bits of an order-n sequence seeded with all ones; mk is the mark
    // ratio code, sh3 the three-bit AND shift, zs inserts the extra zero
    task automatic push_prbs(input int n, input int t, input bit pos, input int mk,
        input bit sh3, input bit zs, input int cnt, input int per);
        logic [30:0] s;
        logic [30:0] m;
        logic [5:0] h;
        logic nb;
        logic rb;
        logic zd;
        s = '1;
        m = 31'((32'h1 << n) - 32'h1);
        h = 6'h0;
        zd = 1'b0;
        for (int i = 0; i < cnt; i++)
        begin
            zd = zs && !zd && ((s & m) == m);
            rb = zd ? 1'b0 : s[n-1] ^ s[t-1];
            if (!zd)
                s = (s << 1) | 31'(rb);
            nb = rb;
            if (mk == 1)
                nb = rb & (sh3 ? h[2] : h[0]);
            else if (mk == 2)
                nb = rb & (sh3 ? h[2] : h[0]) & (sh3 ? h[5] : h[1]);
            else if (mk == 3)
                nb = 1'b0;
            h = {h[4:0], rb};
            exp_q.push_back({pos ? ~nb : nb, (i % per) < 32, 1'b0});
        end
    endtask : push_prbs

    // stale buffered bits are drained with an empty queue so they are ignored
    task automatic run(input logic [31:0] c);
        apb(1'b1, `PPGEN_ADDR_CTRL, c, 32'h0, 1'b0);
        while (exp_q.size() > 0)
            @(posedge clk);
        apb(1'b1, `PPGEN_ADDR_CTRL, c & ~32'h100, 32'h0, 1'b0);
        rx_stall <= 1'b0;
        repeat (8) @(posedge clk);
        rx_stall <= 1'b1;
    endtask : run

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        rx_stall = 1'b1;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, `PPGEN_ADDR_CTRL, 32'h0, `PPGEN_CTRL_RST, 1'b0);
        apb(1'b0, `PPGEN_ADDR_SW, 32'h0, `PPGEN_SW_RST, 1'b0);
        apb(1'b0, `PPGEN_ADDR_LEN, 32'h0, `PPGEN_LEN_RST, 1'b0);
        apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `PPGEN_ADDR_SW, 32'h0f, 32'h0, 1'b0);
        apb(1'b0, `PPGEN_ADDR_SW, 32'h0, 32'h0f, 1'b0);
        apb(1'b1, `PPGEN_ADDR_SW, 32'h0, 32'h0, 1'b0);
        // full period and a second sync pulse
        push_prbs(7, 6, 1'b0, 0, 1'b0, 1'b0, 4104, 4064);
        run(32'h100);
        for (int k = 1; k < 7; k++)
        begin
            push_prbs(n_tab[k], t_tab[k], k % 2, 0, 1'b0, 1'b0, 48, 100000);
            run(32'h100 | 32'(k) | (32'(k % 2) << 5));
        end
        // zero mark ratio gives all zeros
        push_prbs(15, 14, 1'b0, 3, 1'b0, 1'b0, 40, 100000);
        run(32'h11b);
        // zero-sub order 7, 1/4 with three-bit shift
        apb(1'b1, `PPGEN_ADDR_SW, 32'h1, 32'h0, 1'b0);
        push_prbs(7, 6, 1'b0, 1, 1'b1, 1'b1, 300, 128);
        run(32'h1c8);
        // order 9, 1/8 with one-bit shift, positive logic
        apb(1'b1, `PPGEN_ADDR_SW, 32'h0, 32'h0, 1'b0);
        push_prbs(9, 5, 1'b1, 2, 1'b0, 1'b0, 64, 100000);
        run(32'h131);
        // programmed data of length 10 syncs every 640 bits
        r = $random(seed);
        apb(1'b1, `PPGEN_ADDR_MEM, r, 32'h0, 1'b0);
        apb(1'b0, `PPGEN_ADDR_MEM, 32'h0, r, 1'b0);
        apb(1'b1, `PPGEN_ADDR_LEN, 32'd10, 32'h0, 1'b0);
        for (int i = 0; i < 700; i++)
            exp_q.push_back({r[i % 10], (i % 640) < 32, 1'b0});
        run(32'h143);
        // internal select swaps to bank B at the first wrap
        r2 = $random(seed);
        apb(1'b1, `PPGEN_ADDR_MEM + 12'h020, r2, 32'h0, 1'b0);
        for (int i = 0; i < 660; i++)
            exp_q.push_back({(i < 10) ? r[i % 10] : r2[i % 10], (i % 640) < 32, i >= 10});
        run(32'h580);
        conclude();
    end
endmodule : testbench

// >>> src/ppgen_consts.svh
// constants for the bit-pattern generator: register map, field layout,
// reset values and timing counts; included by the package and the testbench
`ifndef PPGEN_CONSTS_SVH
`define PPGEN_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define PPGEN_ADDR_CTRL 12'h000
`define PPGEN_ADDR_SW 12'h004
`define PPGEN_ADDR_LEN 12'h008
`define PPGEN_ADDR_STAT 12'h00c
`define PPGEN_ADDR_MEM 12'h040
`define PPGEN_MEM_WORDS 16

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define PPGEN_CTRL_ORDER 2:0
`define PPGEN_CTRL_MARK 4:3
`define PPGEN_CTRL_POLPOS 5
`define PPGEN_CTRL_MODE 7:6
`define PPGEN_CTRL_OUTEN 8
`define PPGEN_CTRL_ERR 9
`define PPGEN_CTRL_ABINT 10
// order 15, mark ratio 1/2, positive logic, pseudorandom, error off, output off
`define PPGEN_CTRL_RST 32'h0000_0023

// ----------------------------------------------------------------------
// switch register fields
// ----------------------------------------------------------------------
`define PPGEN_SW_SHIFT3 0
`define PPGEN_SW_ABEXT 1
`define PPGEN_SW_ABLOW 2
`define PPGEN_SW_ABHIGH 3
`define PPGEN_SW_RST 32'h0000_0000
`define PPGEN_LEN_RST 32'h0000_0080

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PPGEN_CLK_MHZ 125
`define PPGEN_INIT_RATE_MHZ 12500
`define PPGEN_SYNC_WIDTH 37'h20
`define PPGEN_AB_STEP 7'h7f
`define PPGEN_LCM_LIMIT 32'h0001_0000

`endif

// >>> src/ppgen_pkg.sv
// types shared by the bit-pattern generator core
// assumes ppgen_consts.svh sits on the include path
package ppgen_pkg;

    `include "ppgen_consts.svh"

    typedef enum logic [2:0] {
        PPGEN_O7 = 3'b000,
        PPGEN_O9 = 3'b001,
        PPGEN_O11 = 3'b010,
        PPGEN_O15 = 3'b011,
        PPGEN_O20 = 3'b100,
        PPGEN_O23 = 3'b101,
        PPGEN_O31 = 3'b110
    } ppgen_order_e;

    typedef enum logic [1:0] {
        PPGEN_PRBS = 2'b00,
        PPGEN_DATA = 2'b01,
        PPGEN_ALT = 2'b10,
        PPGEN_ZSUB = 2'b11
    } ppgen_mode_e;

    typedef enum logic [1:0] {
        PPGEN_HALF = 2'b00,
        PPGEN_QUARTER = 2'b01,
        PPGEN_EIGHTH = 2'b10,
        PPGEN_ZERO = 2'b11
    } ppgen_mark_e;

    // one generated bit with its side-band
    typedef struct packed {
        logic data;
        logic sync;
        logic ab;
    } ppgen_word_s;

endpackage : ppgen_pkg

// >>> src/ppgen_top.sv
// pseudorandom and programmable bit-pattern generator with an APB slave
// assumes one 125 MHz clock, APB master synchronous to it, and a receiver
// that takes one bit per cycle when OUT_VALID and OUT_READY are both high
`timescale 1ns/1ps

module ppgen_top
    import ppgen_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // external alternate-pattern select
    input wire logic AB_SELECT,
    // pattern stream
    input wire logic OUT_READY,
    output logic OUT_VALID,
    output logic OUT_DATA,
    output logic OUT_SYNC,
    output logic OUT_AB
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [4:0] order_bits(input logic [2:0] o);
        case (o)
            PPGEN_O7: order_bits = 5'd7;
            PPGEN_O9: order_bits = 5'd9;
            PPGEN_O11: order_bits = 5'd11;
            PPGEN_O15: order_bits = 5'd15;
            PPGEN_O20: order_bits = 5'd20;
            PPGEN_O23: order_bits = 5'd23;
            default: order_bits = 5'd31;
        endcase
    endfunction : order_bits

    function automatic logic [30:0] seed_mask(input logic [2:0] o);
        seed_mask = 31'((32'h1 << order_bits(o)) - 32'h1);
    endfunction : seed_mask

    function automatic logic feedback(input logic [2:0] o, input logic [30:0] s);
        case (o)
            PPGEN_O7: feedback = s[6] ^ s[5];
            PPGEN_O9: feedback = s[8] ^ s[4];
            PPGEN_O11: feedback = s[10] ^ s[8];
            PPGEN_O15: feedback = s[14] ^ s[13];
            PPGEN_O20: feedback = s[19] ^ s[2];
            PPGEN_O23: feedback = s[22] ^ s[17];
            default: feedback = s[30] ^ s[27];
        endcase
    endfunction : feedback

    function automatic logic [36:0] sync_period(input logic [1:0] m, input logic [2:0] o,
                                                input logic [31:0] len);
        logic [31:0] l;
        logic [2:0] tz;
        l = (len == 32'h0) ? 32'h1 : len;
        tz = 3'd7;
        for (int i = 6; i >= 0; i--)
        begin
            if (l[i])
                tz = 3'(i);
        end
        case (m)
            PPGEN_PRBS: sync_period = ((37'h1 << order_bits(o)) - 37'h1) << 5;
            PPGEN_ZSUB: sync_period = 37'h1 << order_bits(o);
            default:
            begin
                if (l <= `PPGEN_LCM_LIMIT)
                    sync_period = {5'h0, l} << (3'd7 - tz);
                else
                    sync_period = {5'h0, l};
            end
        endcase
    endfunction : sync_period

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++)
        begin
            merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : merge

    // ------------------------------------------------------------------
    // registers and apb decode
    // ------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] sw;
    logic [31:0] len_cfg;
    logic [31:0] mem [0:`PPGEN_MEM_WORDS-1];
    logic setup;
    logic wr;
    logic mem_hit;
    logic mapped;
    logic ctrl_wr;
    logic cfg_wr;
    logic [31:0] rd_val;

    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PREADY & PWRITE & mapped;
    assign mem_hit = (PADDR[11:6] == 6'(`PPGEN_ADDR_MEM >> 6));
    assign mapped = (PADDR[1:0] == 2'h0) && (mem_hit || PADDR == `PPGEN_ADDR_CTRL ||
        PADDR == `PPGEN_ADDR_SW || PADDR == `PPGEN_ADDR_LEN || PADDR == `PPGEN_ADDR_STAT);
    assign ctrl_wr = wr && PADDR == `PPGEN_ADDR_CTRL;
    assign cfg_wr = ctrl_wr || (wr && PADDR == `PPGEN_ADDR_LEN);

    // one wait-free access: ready rises in the access phase from the setup edge
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
        end
        else
        begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped;
            if (setup && !PWRITE)
                PRDATA <= mapped ? rd_val : 32'h0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl <= `PPGEN_CTRL_RST;
            sw <= `PPGEN_SW_RST;
            len_cfg <= `PPGEN_LEN_RST;
            for (int i = 0; i < `PPGEN_MEM_WORDS; i++)
                mem[i] <= 32'h0;
        end
        else if (wr)
        begin
            if (mem_hit)
                mem[PADDR[5:2]] <= merge(mem[PADDR[5:2]], PWDATA, PSTRB);
            else if (PADDR == `PPGEN_ADDR_CTRL)
                ctrl <= merge(ctrl, PWDATA, PSTRB);
            else if (PADDR == `PPGEN_ADDR_SW)
                sw <= merge(sw, PWDATA, PSTRB);
            else if (PADDR == `PPGEN_ADDR_LEN)
                len_cfg <= merge(len_cfg, PWDATA, PSTRB);
        end
    end

    // ------------------------------------------------------------------
    // generator state
    // ------------------------------------------------------------------
    logic [2:0] order;
    logic [1:0] mode;
    logic [1:0] mark;
    logic [30:0] lfsr;
    logic [30:0] mask;
    logic zdone;
    logic [31:0] pos;
    logic [5:0] hist;
    logic [36:0] sc;
    logic [36:0] per;
    logic cur_b;
    logic [6:0] div;
    logic step;
    logic [2:0] taps;
    logic [1:0] ab_off;
    logic ab_ext_d;
    logic ab_req;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic adv;
    logic prbs_mode;
    logic fb;
    logic z_take;
    logic seq_raw;
    logic marked;
    logic h_a;
    logic h_b;
    logic wrap;
    ppgen_word_s word;
    ppgen_word_s q0;
    ppgen_word_s q1;

    assign order = ctrl[`PPGEN_CTRL_ORDER];
    assign mode = ctrl[`PPGEN_CTRL_MODE];
    assign mark = ctrl[`PPGEN_CTRL_MARK];
    assign mask = seed_mask(order);
    assign prbs_mode = (mode == PPGEN_PRBS) || (mode == PPGEN_ZSUB);
    // generation halts while the output is off or the buffer is full
    assign adv = ctrl[`PPGEN_CTRL_OUTEN] && (cnt != 2'd2);
    assign fb = feedback(order, lfsr);
    // zero substitution: one extra zero after the all-ones state makes 2^N
    assign z_take = (mode == PPGEN_ZSUB) && !zdone && ((lfsr & mask) == mask);
    // a zero length acts as one bit
    assign wrap = (len_cfg == 32'h0) || (pos >= len_cfg - 32'h1);

    always_comb
    begin
        if (prbs_mode)
            seq_raw = z_take ? 1'b0 : fb;
        else
            seq_raw = mem[{(mode == PPGEN_ALT) & cur_b, pos[7:5]}][pos[4:0]];
    end

    assign h_a = sw[`PPGEN_SW_SHIFT3] ? hist[2] : hist[0];
    assign h_b = sw[`PPGEN_SW_SHIFT3] ? hist[5] : hist[1];

    always_comb
    begin
        marked = seq_raw;
        if (prbs_mode)
        begin
            unique case (mark)
                PPGEN_HALF: marked = seq_raw;
                PPGEN_QUARTER: marked = seq_raw & h_a;
                PPGEN_EIGHTH: marked = seq_raw & h_a & h_b;
                PPGEN_ZERO: marked = 1'b0;
            endcase
        end
    end

    assign word.data = (ctrl[`PPGEN_CTRL_POLPOS] ? ~marked : marked) ^
        (ctrl[`PPGEN_CTRL_ERR] && sc == 37'h0);
    assign word.sync = sc < `PPGEN_SYNC_WIDTH;
    assign word.ab = cur_b;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            lfsr <= 31'h7fff_ffff;
            zdone <= 1'b0;
        end
        else if (cfg_wr)
        begin
            lfsr <= 31'h7fff_ffff;
            zdone <= 1'b0;
        end
        else if (adv && prbs_mode)
        begin
            zdone <= z_take;
            if (!z_take)
                lfsr <= {lfsr[29:0], fb};
        end
    end

    // history of raw bits feeds the mark-ratio ANDs
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            hist <= 6'h0;
        else if (cfg_wr)
            hist <= 6'h0;
        else if (adv)
            hist <= {hist[4:0], seq_raw};
    end

    // pattern memory position; lengths past 256 wrap inside the bank
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            pos <= 32'h0;
        else if (cfg_wr)
            pos <= 32'h0;
        else if (adv && !prbs_mode)
            pos <= wrap ? 32'h0 : pos + 32'h1;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            per <= 37'h0;
            sc <= 37'h0;
        end
        else
        begin
            per <= sync_period(mode, order, len_cfg);
            if (cfg_wr)
                sc <= 37'h0;
            else if (adv)
                sc <= (sc >= per - 37'h1) ? 37'h0 : sc + 37'h1;
        end
    end

    // ------------------------------------------------------------------
    // alternate pattern select
    // ------------------------------------------------------------------
    // 128 clock step
    assign step = (div == `PPGEN_AB_STEP);
    assign ab_off = {sw[`PPGEN_SW_ABHIGH], sw[`PPGEN_SW_ABLOW]};

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            div <= 7'h0;
            taps <= 3'h0;
        end
        else
        begin
            div <= div + 7'h1;
            if (step)
                taps <= {taps[1:0], AB_SELECT};
        end
    end

    always_comb
    begin
        unique case (ab_off)
            2'b00: ab_ext_d = AB_SELECT;
            2'b01: ab_ext_d = taps[0];
            2'b10: ab_ext_d = taps[1];
            2'b11: ab_ext_d = taps[2];
        endcase
    end

    assign ab_req = sw[`PPGEN_SW_ABEXT] ? ab_ext_d : ctrl[`PPGEN_CTRL_ABINT];

    // bank changes only on a pattern boundary so A and B stay whole
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            cur_b <= 1'b0;
        else if (cfg_wr)
            cur_b <= 1'b0;
        else if (adv && mode == PPGEN_ALT && wrap)
            cur_b <= ab_req;
    end

    // ------------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------------
    logic pop;

    assign pop = OUT_VALID & OUT_READY;

    always_comb
    begin
        next_cnt = cnt;
        if (adv && !pop)
            next_cnt = cnt + 2'd1;
        else if (!adv && pop)
            next_cnt = cnt - 2'd1;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cnt <= 2'd0;
            q0 <= '0;
            q1 <= '0;
            OUT_VALID <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            OUT_VALID <= next_cnt != 2'd0;
            if (adv && !pop)
            begin
                if (cnt == 2'd0)
                    q0 <= word;
                else
                    q1 <= word;
            end
            else if (!adv && pop)
                q0 <= q1;
            else if (adv && pop)
            begin
                if (cnt == 2'd1)
                    q0 <= word;
                else
                begin
                    q0 <= q1;
                    q1 <= word;
                end
            end
        end
    end

    assign OUT_DATA = q0.data;
    assign OUT_SYNC = q0.sync;
    assign OUT_AB = q0.ab;

    // status: live sequence state and current bank
    assign rd_val = mem_hit ? mem[PADDR[5:2]] :
        (PADDR == `PPGEN_ADDR_CTRL) ? ctrl :
        (PADDR == `PPGEN_ADDR_SW) ? sw :
        (PADDR == `PPGEN_ADDR_LEN) ? len_cfg :
        {cur_b, lfsr};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_step_gap;
        !step [*8];
    endsequence

    property p_seed_nonzero;
        (lfsr & mask) != 31'h0;
    endproperty
    a_seed_nonzero: assert property (p_seed_nonzero) else $error("sequence locked at zero");

    property p_reseed;
        ctrl_wr |=> lfsr == 31'h7fff_ffff && sc == 37'h0;
    endproperty
    a_reseed: assert property (p_reseed) else $error("no reseed after order write");

    property p_taps15;
        adv && !cfg_wr && mode == PPGEN_PRBS && order == PPGEN_O15
            |=> lfsr[0] == ($past(lfsr[14]) ^ $past(lfsr[13]));
    endproperty
    a_taps15: assert property (p_taps15) else $error("order 15 feedback wrong");

    property p_taps31;
        adv && !cfg_wr && mode == PPGEN_PRBS && order == PPGEN_O31
            |=> lfsr[0] == ($past(lfsr[30]) ^ $past(lfsr[27]));
    endproperty
    a_taps31: assert property (p_taps31) else $error("order 31 feedback wrong");

    property p_polarity;
        prbs_mode && !z_take && mark == PPGEN_HALF && !ctrl[`PPGEN_CTRL_ERR]
            |-> word.data == (fb ^ ctrl[`PPGEN_CTRL_POLPOS]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity mapping wrong");

    property p_mark_zero;
        prbs_mode && mark == PPGEN_ZERO && !ctrl[`PPGEN_CTRL_ERR]
            |-> word.data == ctrl[`PPGEN_CTRL_POLPOS];
    endproperty
    a_mark_zero: assert property (p_mark_zero) else $error("0/8 not all zeros");

    property p_step_gap;
        step |=> s_step_gap ##120 step;
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("offset step not 128 clocks");

    property p_offset_one;
        step |=> taps[0] == $past(AB_SELECT);
    endproperty
    a_offset_one: assert property (p_offset_one) else $error("select not delayed a step");

    property p_sync_width;
        adv && !cfg_wr && sc == 37'h1f && per > 37'h20 |=> !word.sync && sc == 37'h20;
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync pulse not 32 wide");

    property p_period_prbs7;
        mode == PPGEN_PRBS && order == PPGEN_O7 && !$past(cfg_wr) |-> per == 37'd4064;
    endproperty
    a_period_prbs7: assert property (p_period_prbs7) else $error("order 7 period wrong");

endmodule : ppgen_top
